// ==== include/bright_ps_pkg.sv ====
package bright_ps_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_LEVEL = 8'h51;
    localparam logic [7:0] IDX_CTRL_WR = 8'h53;
    localparam logic [7:0] IDX_CTRL_RD = 8'h54;
    localparam logic [7:0] IDX_PS_WR = 8'h55;
    localparam logic [7:0] IDX_PS_RD = 8'h56;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_SW_RESET = 8'h70;

    // ==========================================================
    // display-control field positions and reset values
    localparam int GATE_BIT = 5;
    localparam int DIM_BIT = 3;
    localparam int BL_BIT = 2;
    localparam int STATUS_ACTIVE_BIT = 16;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PS_RESET = 8'h00;
    localparam logic [11:0] LEVEL_RESET = 12'h000;
    localparam logic [11:0] LEVEL_OFF = 12'h000;

    // ==========================================================
    // power-save codes
    localparam logic [7:0] PS_OFF = 8'h00;
    localparam logic [7:0] PS_LOW = 8'h01;
    localparam logic [7:0] PS_MEDIUM = 8'h02;
    localparam logic [7:0] PS_HIGH = 8'h03;
    localparam logic [3:0] IE_LOW_NIB = 4'h8;
    localparam logic [3:0] IE_MEDIUM_NIB = 4'h9;
    localparam logic [3:0] IE_HIGH_NIB = 4'hB;
    localparam logic [3:0] SRE_LOW_NIB = 4'h4;
    localparam logic [3:0] SRE_MEDIUM_NIB = 4'h5;
    localparam logic [3:0] SRE_HIGH_NIB = 4'h6;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_MEDIUM = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DIM_STEP_TIME_NS = 1000;
    localparam int DIM_STEP_CYCLES = (DIM_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // dimming ramp states
    typedef enum logic [1:0] {
        RAMP_HOLD = 2'b01,
        RAMP_GLIDE = 2'b10
    } ramp_state_e;

    function automatic logic [9:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

endpackage : bright_ps_pkg

// ==== design/brightness_ramp.sv ====
`timescale 1ns/1ns
`default_nettype none

module brightness_ramp (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic [11:0] target,
    input wire logic glide,
    // result
    output logic [11:0] level,
    output logic active
);

    // ==========================================================
    // step timer and one-LSB stepping toward the target
    bright_ps_pkg::ramp_state_e state_q;
    logic [11:0] level_q;
    logic [7:0] tick_q;
    wire tick_done = (tick_q == 8'(bright_ps_pkg::DIM_STEP_CYCLES - 1));
    wire at_target = (level_q == target);
    wire [11:0] step_val = (level_q < target) ? level_q + 12'h001 : level_q - 12'h001;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= bright_ps_pkg::RAMP_HOLD;
            level_q <= bright_ps_pkg::LEVEL_RESET;
            tick_q <= 8'h00;
        end else begin
            unique case (state_q)
                bright_ps_pkg::RAMP_HOLD: begin
                    tick_q <= 8'h00;
                    if (glide && !at_target) begin
                        state_q <= bright_ps_pkg::RAMP_GLIDE;
                    end else begin
                        level_q <= target;
                    end
                end
                bright_ps_pkg::RAMP_GLIDE: begin
                    tick_q <= tick_done ? 8'h00 : tick_q + 8'h01;
                    if (!glide || at_target) begin
                        // a cancelled glide lands on the target at once
                        level_q <= target;
                        state_q <= bright_ps_pkg::RAMP_HOLD;
                    end else if (tick_done) begin
                        level_q <= step_val;
                    end
                end
                default: begin
                    state_q <= bright_ps_pkg::RAMP_HOLD;
                end
            endcase
        end
    end

    assign level = level_q;
    assign active = (state_q == bright_ps_pkg::RAMP_GLIDE);

endmodule : brightness_ramp

`default_nettype wire

// ==== design/power_save_decode.sv ====
`timescale 1ns/1ns
`default_nettype none

module power_save_decode (
    // stored setting
    input wire logic [7:0] setting,
    // decoded modes
    output logic [1:0] content_adaptive_brightness_level,
    output logic [1:0] ie_level,
    output logic [1:0] sre_level,
    output logic reserved
);

    // ==========================================================
    // low nibble is ignored for enhancement codes
    wire [3:0] nib = setting[7:4];
    wire is_off = (setting == bright_ps_pkg::PS_OFF);
    wire is_ps_low = (setting == bright_ps_pkg::PS_LOW);
    wire is_ps_med = (setting == bright_ps_pkg::PS_MEDIUM);
    wire is_ps_high = (setting == bright_ps_pkg::PS_HIGH);
    wire is_ie_low = (nib == bright_ps_pkg::IE_LOW_NIB);
    wire is_ie_med = (nib == bright_ps_pkg::IE_MEDIUM_NIB);
    wire is_ie_high = (nib == bright_ps_pkg::IE_HIGH_NIB);
    wire is_sre_low = (nib == bright_ps_pkg::SRE_LOW_NIB);
    wire is_sre_med = (nib == bright_ps_pkg::SRE_MEDIUM_NIB);
    wire is_sre_high = (nib == bright_ps_pkg::SRE_HIGH_NIB);

    assign content_adaptive_brightness_level = is_ps_low ? bright_ps_pkg::LVL_LOW :
                        is_ps_med ? bright_ps_pkg::LVL_MEDIUM :
                        is_ps_high ? bright_ps_pkg::LVL_HIGH : bright_ps_pkg::LVL_NONE;
    assign ie_level = is_ie_low ? bright_ps_pkg::LVL_LOW :
                      is_ie_med ? bright_ps_pkg::LVL_MEDIUM :
                      is_ie_high ? bright_ps_pkg::LVL_HIGH : bright_ps_pkg::LVL_NONE;
    assign sre_level = is_sre_low ? bright_ps_pkg::LVL_LOW :
                       is_sre_med ? bright_ps_pkg::LVL_MEDIUM :
                       is_sre_high ? bright_ps_pkg::LVL_HIGH : bright_ps_pkg::LVL_NONE;
    assign reserved = !(is_off || is_ps_low || is_ps_med || is_ps_high || is_ie_low
                        || is_ie_med || is_ie_high || is_sre_low || is_sre_med || is_sre_high);

endmodule : power_save_decode

`default_nettype wire

// ==== design/brightness_ctrl_power_save_regs.sv ====
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module brightness_ctrl_power_save_regs (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // brightness and backlight
    output logic [11:0] BRIGHTNESS_OUT,
    output logic BACKLIGHT_ON,
    output logic DIMMING_ACTIVE,
    // power-save modes
    output logic [1:0] CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL,
    output logic [1:0] IE_LEVEL,
    output logic [1:0] SRE_LEVEL,
    output logic PS_RESERVED
);

    // ==========================================================
    // address phase capture
    logic wr_pend_q;
    logic [9:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic readyout_q;

    wire addr_phase = HSEL && HTRANS[1] && HREADY;
    wire rd_now = addr_phase && !HWRITE;
    wire wr_now = addr_phase && HWRITE;
    wire [9:0] rd_addr = HADDR[9:0];

    // only word writes carry data; anything else is a harmless no-op
    logic wr_word_q;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
            wr_word_q <= 1'b0;
            readyout_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_now;
            wr_addr_q <= wr_now ? HADDR[9:0] : wr_addr_q;
            wr_word_q <= (HSIZE == 3'h2);
            readyout_q <= 1'b1;
        end
    end

    // ==========================================================
    // write decode (data phase)
    wire wr_ok = wr_pend_q && wr_word_q;
    wire wr_level = wr_ok && (wr_addr_q == bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_LEVEL));
    wire wr_ctrl = wr_ok && (wr_addr_q == bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_CTRL_WR));
    wire wr_ps = wr_ok && (wr_addr_q == bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_PS_WR));
    wire wr_swrst = wr_ok
        && (wr_addr_q == bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_SW_RESET));

    // ==========================================================
    // stored settings
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] ps_q;
    logic [7:0] ps_d;
    logic [11:0] level_q;
    logic [11:0] level_d;
    logic glide_q;
    logic glide_d;

    // unused control bits never store, so they read back as zero
    wire [7:0] ctrl_mask = (8'h01 << bright_ps_pkg::GATE_BIT)
                         | (8'h01 << bright_ps_pkg::DIM_BIT)
                         | (8'h01 << bright_ps_pkg::BL_BIT);

    wire gate_on = ctrl_q[bright_ps_pkg::GATE_BIT];
    wire dim_on = ctrl_q[bright_ps_pkg::DIM_BIT];
    wire bl_on = ctrl_q[bright_ps_pkg::BL_BIT];
    wire [7:0] ctrl_new = HWDATA[7:0] & ctrl_mask;
    wire gate_flip = wr_ctrl && (ctrl_new[bright_ps_pkg::GATE_BIT] != gate_on);
    wire dim_new = ctrl_new[bright_ps_pkg::DIM_BIT];

    // ==========================================================
    // effective target and ramp
    wire [11:0] ramp_level;
    wire ramp_active;
    wire [11:0] target = gate_on ? level_q : bright_ps_pkg::LEVEL_OFF;

    // software reset returns everything to its reset value
    assign ctrl_d = wr_swrst ? bright_ps_pkg::CTRL_RESET :
                    wr_ctrl ? ctrl_new : ctrl_q;
    assign ps_d = wr_swrst ? bright_ps_pkg::PS_RESET :
                  wr_ps ? HWDATA[7:0] : ps_q;
    assign level_d = wr_swrst ? bright_ps_pkg::LEVEL_RESET :
                     wr_level ? HWDATA[11:0] : level_q;

    // glide only on a gate toggle while dimming is on; a plain level rewrite
    // or dimming off lands at once
    assign glide_d = wr_swrst ? 1'b0 :
                     gate_flip ? dim_new :
                     (wr_ctrl && !dim_new) ? 1'b0 :
                     wr_level ? 1'b0 :
                     (glide_q && ramp_active && (ramp_level == target)) ? 1'b0 :
                     glide_q;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= bright_ps_pkg::CTRL_RESET;
            ps_q <= bright_ps_pkg::PS_RESET;
            level_q <= bright_ps_pkg::LEVEL_RESET;
            glide_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ps_q <= ps_d;
            level_q <= level_d;
            glide_q <= glide_d;
        end
    end

    brightness_ramp u_ramp (
        .clk(CLK),
        .rst_n(RESETN),
        .target(target),
        .glide(glide_q),
        .level(ramp_level),
        .active(ramp_active)
    );

    // ==========================================================
    // power-save decode
    wire [1:0] content_adaptive_brightness_lvl;
    wire [1:0] ie_lvl;
    wire [1:0] sre_lvl;
    wire ps_rsv;

    power_save_decode u_ps_decode (
        .setting(ps_q),
        .content_adaptive_brightness_level(content_adaptive_brightness_lvl),
        .ie_level(ie_lvl),
        .sre_level(sre_lvl),
        .reserved(ps_rsv)
    );

    // ==========================================================
    // read mux: built from next values so a read right behind a write
    // sees the new data without a wait state
    wire [9:0] a_ctrl_rd = bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_CTRL_RD);
    wire [9:0] a_ps_rd = bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_PS_RD);
    wire [9:0] a_level = bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_LEVEL);
    wire [9:0] a_status = bright_ps_pkg::byte_addr(bright_ps_pkg::IDX_STATUS);
    wire hi_zero = (HADDR[31:10] == 22'h000000);
    wire sel_ctrl_rd = hi_zero && (rd_addr == a_ctrl_rd);
    wire sel_ps_rd = hi_zero && (rd_addr == a_ps_rd);
    wire sel_level = hi_zero && (rd_addr == a_level);
    wire sel_status = hi_zero && (rd_addr == a_status);
    wire [31:0] status_word = {15'h0000, ramp_active, 4'h0, BRIGHTNESS_OUT};

    // control readback has no power-state gate, so it answers under every power-save setting
    wire [31:0] rd_mux = sel_ctrl_rd ? {24'h000000, ctrl_d} :
                         sel_ps_rd ? {24'h000000, ps_d} :
                         sel_level ? {20'h00000, level_d} :
                         sel_status ? status_word : 32'h00000000;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd_now ? rd_mux : 32'h00000000;
        end
    end

    // ==========================================================
    // registered outputs
    logic [11:0] bright_q;
    logic bl_q;
    logic dim_act_q;
    logic [1:0] content_adaptive_brightness_q;
    logic [1:0] ie_q;
    logic [1:0] sre_q;
    logic rsv_q;

    // backlight off bypasses the ramp entirely
    wire bl_next = ctrl_d[bright_ps_pkg::BL_BIT];
    wire [11:0] bright_next = bl_next ? ramp_level : bright_ps_pkg::LEVEL_OFF;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bright_q <= bright_ps_pkg::LEVEL_RESET;
            bl_q <= 1'b0;
            dim_act_q <= 1'b0;
            content_adaptive_brightness_q <= bright_ps_pkg::LVL_NONE;
            ie_q <= bright_ps_pkg::LVL_NONE;
            sre_q <= bright_ps_pkg::LVL_NONE;
            rsv_q <= 1'b0;
        end else begin
            bright_q <= bright_next;
            bl_q <= bl_next;
            dim_act_q <= ramp_active && bl_on;
            content_adaptive_brightness_q <= content_adaptive_brightness_lvl;
            ie_q <= ie_lvl;
            sre_q <= sre_lvl;
            rsv_q <= ps_rsv;
        end
    end

    assign HRDATA = rdata_q;
    assign HREADYOUT = readyout_q;
    assign HRESP = 1'b0;
    assign BRIGHTNESS_OUT = bright_q;
    assign BACKLIGHT_ON = bl_q;
    assign DIMMING_ACTIVE = dim_act_q;
    assign CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL = content_adaptive_brightness_q;
    assign IE_LEVEL = ie_q;
    assign SRE_LEVEL = sre_q;
    assign PS_RESERVED = rsv_q;

    // dim_on is kept for readability of the glide path
    wire unused_dim = dim_on;

endmodule : brightness_ctrl_power_save_regs

`default_nettype wire

// ==== test/bright_ps_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// host processor: single-word bus master
module bright_ps_host (
    // clock
    input wire logic CLK,
    // answer
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    // request
    output logic HSEL,
    output logic [31:0] HADDR,
    output logic [1:0] HTRANS,
    output logic HWRITE,
    output logic [2:0] HSIZE,
    output logic [31:0] HWDATA
);
    int timeouts = 0;
    initial begin
        HSEL = 1'b0;
        HADDR = 32'h00000000;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h00000000;
    end
    // bounded wait: a slave that never answers is counted, not hung on
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADY !== 1'b1 && n < 50);
        if (HREADY !== 1'b1) timeouts++;
    endtask : wait_ready
    // one command parameter is exactly one word transfer
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HSIZE <= 3'h2;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
        // released data lines never keep the last value
        HWDATA <= ~wd;
    endtask : xfer
endmodule : bright_ps_host
`default_nettype wire

// ==== test/brightness_ctrl_power_save_regs_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checks
module brightness_ctrl_power_save_regs_asserts (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // outputs
    input wire logic [11:0] BRIGHTNESS_OUT,
    input wire logic BACKLIGHT_ON,
    input wire logic DIMMING_ACTIVE,
    input wire logic [1:0] CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL,
    input wire logic [1:0] IE_LEVEL,
    input wire logic [1:0] SRE_LEVEL,
    input wire logic PS_RESERVED
);
    logic taken;
    logic rd_q;
    logic rd_ctrl_q;
    logic wr_ctrl_q;
    assign taken = HSEL && HTRANS[1] && HREADY;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_q <= 1'b0;
            rd_ctrl_q <= 1'b0;
            wr_ctrl_q <= 1'b0;
        end else begin
            rd_q <= taken && !HWRITE;
            rd_ctrl_q <= taken && !HWRITE && HADDR == 32'h00000150;
            wr_ctrl_q <= taken && HWRITE && HSIZE == 3'h2 && HADDR == 32'h0000014C;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_bl_set; wr_ctrl_q && HWDATA[2]; endsequence
    sequence s_bl_clear; wr_ctrl_q && !HWDATA[2]; endsequence
    sequence s_gliding; (DIMMING_ACTIVE && BACKLIGHT_ON) [*2]; endsequence
    a_okay_ready: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    a_rdata_idle: assert property (!rd_q |-> HRDATA == 32'h00000000)
        else $error("read data outside a read data phase");
    a_ctrl_mask: assert property (rd_ctrl_q |-> (HRDATA & 32'hFFFFFFD3) == 32'h0)
        else $error("control read shows an unused bit");
    a_bl_on: assert property (s_bl_set |-> ##2 BACKLIGHT_ON)
        else $error("backlight not on after control write");
    a_bl_off_now: assert property (s_bl_clear |-> ##2 (!BACKLIGHT_ON && !DIMMING_ACTIVE
        && BRIGHTNESS_OUT == 12'h000))
        else $error("backlight off was not immediate");
    a_dark_when_off: assert property (!BACKLIGHT_ON |-> BRIGHTNESS_OUT == 12'h000)
        else $error("brightness while backlight off");
    a_glide_step: assert property (s_gliding |-> (BRIGHTNESS_OUT - $past(BRIGHTNESS_OUT))
        inside {12'h000, 12'h001, 12'hFFF})
        else $error("brightness jumped during glide");
    a_one_mode: assert property ($onehot0({|CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL, |IE_LEVEL, |SRE_LEVEL}))
        else $error("more than one power-save mode active");
    a_reserved_quiet: assert property (PS_RESERVED |-> {CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL, IE_LEVEL, SRE_LEVEL}
        == 6'h00)
        else $error("reserved code selects a mode");
endmodule : brightness_ctrl_power_save_regs_asserts
bind brightness_ctrl_power_save_regs brightness_ctrl_power_save_regs_asserts chk (
    .CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA,
    .HREADYOUT, .HRESP, .BRIGHTNESS_OUT, .BACKLIGHT_ON, .DIMMING_ACTIVE, .CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL,
    .IE_LEVEL, .SRE_LEVEL, .PS_RESERVED);
`default_nettype wire

// ==== test/brightness_ctrl_power_save_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module brightness_ctrl_power_save_regs_tb;
    localparam logic [7:0] LVL = bright_ps_pkg::IDX_LEVEL;
    localparam logic [7:0] CTL = bright_ps_pkg::IDX_CTRL_WR;
    localparam logic [7:0] CTR = bright_ps_pkg::IDX_CTRL_RD;
    localparam logic [7:0] PSW = bright_ps_pkg::IDX_PS_WR;
    localparam logic [7:0] PSR = bright_ps_pkg::IDX_PS_RD;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [11:0] bright;
    logic bl_on;
    logic dim_act;
    logic [1:0] content_adaptive_brightness;
    logic [1:0] ie;
    logic [1:0] sunlight_readability;
    logic ps_res;
    logic [31:0] rd;
    int mismatches = 0;
    int samples_checked = 0;
    always #20 CLK = ~CLK;
    brightness_ctrl_power_save_regs dut (.CLK(CLK), .RESETN(RESETN), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .BRIGHTNESS_OUT(bright), .BACKLIGHT_ON(bl_on), .DIMMING_ACTIVE(dim_act),
        .CONTENT_ADAPTIVE_BRIGHTNESS_LEVEL(content_adaptive_brightness), .IE_LEVEL(ie), .SRE_LEVEL(sunlight_readability), .PS_RESERVED(ps_res));
    bright_ps_host host (.CLK(CLK), .HREADY(hready), .HRDATA(hrdata), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, {22'h000000, idx, 2'h0}, d, rd);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, {22'h000000, idx, 2'h0}, 32'h00000000, rd);
        check(what, rd, exp);
    endtask : rd_chk
    // ==========================================
    // scenarios
    task automatic t_defaults;
        rd_chk("ctrl", CTR, 32'h0);
        rd_chk("power save", PSR, 32'h0);
        check("outputs", 32'({bright, bl_on, dim_act, content_adaptive_brightness, ie, sunlight_readability, ps_res}), 32'h0);
    endtask : t_defaults
    task automatic t_fields;
        wr(LVL, 32'h00000ABC);
        wr(CTL, 32'h000000F7);
        rd_chk("ctrl bits", CTR, 32'h00000024);
        repeat (4) @(posedge CLK);
        check("gate on", 32'({bl_on, bright}), 32'h00001ABC);
        wr(CTL, 32'h00000004);
        repeat (4) @(posedge CLK);
        check("gate off", 32'({bl_on, bright}), 32'h00001000);
        wr(CTL, 32'h00000020);
        repeat (4) @(posedge CLK);
        check("backlight off", 32'({bl_on, bright}), 32'h0);
    endtask : t_fields
    task automatic t_glide;
        int n;
        wr(LVL, 32'h00000010);
        wr(CTL, 32'h00000004);
        wr(CTL, 32'h0000002C);
        rd_chk("ctrl dim", CTR, 32'h0000002C);
        repeat (30) @(posedge CLK);
        check("glide up", 32'({dim_act, bright < 12'h010}), 32'h3);
        n = 0;
        while (bright !== 12'h010 && n < 600) begin
            @(posedge CLK);
            n++;
        end
        check("glide top", 32'(bright), 32'h10);
        wr(CTL, 32'h0000000C);
        repeat (30) @(posedge CLK);
        check("glide down", 32'({dim_act, bright != 12'h0, bright < 12'h010}), 32'h7);
        wr(CTL, 32'h00000008);
        repeat (3) @(posedge CLK);
        check("cut", 32'({bl_on, dim_act, bright}), 32'h0);
    endtask : t_glide
    task automatic t_codes;
        logic [7:0] code [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h8F, 8'h95, 8'hBA, 8'h43,
            8'h5C, 8'h60, 8'h07, 8'hA5};
        logic [6:0] want [12] = '{7'h00, 7'h20, 7'h40, 7'h60, 7'h08, 7'h10, 7'h18, 7'h02,
            7'h04, 7'h06, 7'h01, 7'h01};
        for (int i = 0; i < 12; i++) begin
            wr(PSW, {24'h000000, code[i]});
            rd_chk("ps readback", PSR, {24'h000000, code[i]});
            repeat (2) @(posedge CLK);
            check("ps mode", 32'({content_adaptive_brightness, ie, sunlight_readability, ps_res}), 32'(want[i]));
        end
    endtask : t_codes
    task automatic t_resets;
        wr(PSW, 32'h00000095);
        wr(CTL, 32'h00000024);
        wr(bright_ps_pkg::IDX_SW_RESET, 32'h00000000);
        rd_chk("ps soft reset", PSR, 32'h0);
        rd_chk("ctrl soft reset", CTR, 32'h0);
        wr(PSR, 32'h000000FF);
        rd_chk("read-only write", PSR, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        wr(PSW, 32'h00000043);
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        rd_chk("ps hard reset", PSR, 32'h0);
    endtask : t_resets
    // ==========================================
    // run
    task automatic print_verdict;
        mismatches += host.timeouts;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        t_defaults();
        t_fields();
        t_glide();
        t_codes();
        t_resets();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        print_verdict();
    end
endmodule : brightness_ctrl_power_save_regs_tb
`default_nettype wire
